// ==== sim/rcvsr_host_model.sv ====
// host side of the three-wire read interface
`timescale 1ns/1ps
module rcvsr_host_model (
  input wire logic clk,
  output logic serChipEnable,
  output logic serClk,
  output logic [7:0] serAddr,
  input wire logic serReadData
);
  // pins idle low until the first read
  initial
  begin
    serChipEnable = 1'b0;
    serClk = 1'b0;
    serAddr = 8'h00;
  end
  // address settles before select; slow clock since the pins are synchronised
  task automatic rd(input logic [7:0] a, input int n, output logic [87:0] d);
    d = '0;
    @(posedge clk) serAddr <= a;
    repeat (3) @(posedge clk);
    serChipEnable <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk) d[k] = serReadData;
      @(posedge clk) serClk <= 1'b1;
      repeat (4) @(posedge clk);
      serClk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    serChipEnable <= 1'b0;
    serAddr <= ~a;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== sim/rcvsr_readout_properties.sv ====
// checker of the status readout ports
`timescale 1ns/1ps
module rcvsr_readout_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rcvsr_pkg::rcvsr_live_t live,
  input wire logic [2:0] rateCode,
  input wire logic quadRateSelect,
  input wire logic chanStatusUpdate,
  input wire logic subqLoad,
  input wire logic intPinIsIrq,
  input wire logic intPulseMode,
  input wire logic [6:0] intEnable,
  input wire logic serChipEnable,
  input wire logic serReadData,
  input wire logic intPin,
  input wire logic [2:0] rateCodeOut,
  input wire logic quadRateActive
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // level interrupt mode
  sequence s_lvl; intPinIsIrq && !intPulseMode; endsequence
  // five low cycles, so no read start is still in the synchroniser
  sequence s_ceIdle; !serChipEnable [*5]; endsequence
  property p_rateCopy; !$past(sys_rst) |-> rateCodeOut == $past(rateCode); endproperty
  a_rateCopy: assert property (p_rateCopy) else $error("rate copy");
  property p_quadCopy; !$past(sys_rst) |-> quadRateActive == $past(quadRateSelect); endproperty
  a_quadCopy: assert property (p_quadCopy) else $error("quad copy");
  property p_idleZero; s_ceIdle |-> !serReadData; endproperty
  a_idleZero: assert property (p_idleZero) else $error("read data idle");
  property p_emph; (!intPinIsIrq && $stable(live.emphasis)) [*3] |-> intPin == live.emphasis;
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis pin");
  property p_hold; s_ceIdle ##0 s_lvl ##0 intPin |=> intPin; endproperty
  a_hold: assert property (p_hold) else $error("level dropped");
  property p_subqFire; s_lvl ##0 (subqLoad && intEnable[6]) |-> ##[1:3] intPin; endproperty
  a_subqFire: assert property (p_subqFire) else $error("subq event");
  property p_csFire; s_lvl ##0 (chanStatusUpdate && intEnable[5]) |-> ##[1:3] intPin;
  endproperty
  a_csFire: assert property (p_csFire) else $error("status event");
  property p_rateFire;
    s_lvl ##0 (intEnable[4] && !$past(sys_rst) && rateCode != $past(rateCode)) |-> ##[1:3] intPin;
  endproperty
  a_rateFire: assert property (p_rateFire) else $error("rate event");
endmodule
bind rcvsr_readout rcvsr_readout_properties u_rcvsr_readout_properties (.clk, .sys_rst,
  .live, .rateCode, .quadRateSelect, .chanStatusUpdate, .subqLoad, .intPinIsIrq,
  .intPulseMode, .intEnable, .serChipEnable, .serReadData, .intPin, .rateCodeOut,
  .quadRateActive);

// ==== sim/test_rcvsr_readout.sv ====
// self-checking bench for the receiver status readout
`timescale 1ns/1ps
module test_rcvsr_readout;
  logic clk, sys_rst, quadRateSelect, chanStatusUpdate, subqCrcOk, subqLoad, intPinIsIrq;
  logic intPulseMode, serChipEnable, serClk, serReadData, intPin, quadRateActive;
  logic [2:0] rateCode, rateCodeOut;
  logic [6:0] intEnable;
  logic [7:0] serAddr;
  logic [47:0] chanStatusBits;
  logic [79:0] subqData;
  logic [87:0] d;
  rcvsr_pkg::rcvsr_live_t live;
  int fails, tests_run;
  // ---------------
  // design and host
  // ---------------
  rcvsr_readout u_rcvsr_readout (.clk, .sys_rst, .live, .rateCode, .quadRateSelect,
    .chanStatusBits, .chanStatusUpdate, .subqData, .subqCrcOk, .subqLoad, .intPinIsIrq,
    .intPulseMode, .intEnable, .serChipEnable, .serClk, .serAddr, .serReadData, .intPin,
    .rateCodeOut, .quadRateActive);
  rcvsr_host_model u_rcvsr_host_model (.clk, .serChipEnable, .serClk, .serAddr, .serReadData);
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [87:0] e, input logic [87:0] g);
    tests_run++;
    if (e !== g)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle event strobes
  task automatic evt(input logic cs, input logic sq);
    @(posedge clk) chanStatusUpdate <= cs;
    subqLoad <= sq;
    @(posedge clk) chanStatusUpdate <= 1'b0;
    subqLoad <= 1'b0;
  endtask
  task automatic t_irq;
    @(posedge clk) live <= 4'hb;
    rateCode <= 3'h2;
    evt(1'b1, 1'b1);
    repeat (3) @(negedge clk);
    chk("intPin set", 88'h1, 88'(intPin));
    u_rcvsr_host_model.rd(8'heb, 8, d);
    chk("irq first", 88'hfa, d);
    u_rcvsr_host_model.rd(8'heb, 8, d);
    chk("irq again", 88'h1a, d);
    @(negedge clk);
    chk("intPin clear", 88'h0, 88'(intPin));
    $display("irq test done");
  endtask
  task automatic t_rate;
    @(posedge clk) intPinIsIrq <= 1'b0;
    repeat (4) @(negedge clk);
    chk("emphasis pin", 88'h1, 88'(intPin));
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk) rateCode <= 3'(c);
      quadRateSelect <= c[0];
      intPinIsIrq <= 1'b1;
      repeat (2) @(negedge clk);
      chk("rate out", 88'({c[0], 3'(c)}), 88'({quadRateActive, rateCodeOut}));
    end
    @(posedge clk) chanStatusBits <= 48'h5a12_34c3_f00e;
    live <= 4'h4;
    rateCode <= 3'h6;
    evt(1'b1, 1'b0);
    u_rcvsr_host_model.rd(8'hec, 56, d);
    chk("rate reg", {32'h0, 48'h5a12_34c3_f00e, 8'h64}, d);
    $display("rate test done");
  endtask
  // bad then good crc; the last read hits an unmapped address
  task automatic t_subq;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) subqData <= 80'h0123_4567_89ab_cdef_f00d ^ {80{k[0]}};
      subqCrcOk <= k[0];
      evt(1'b0, 1'b1);
      u_rcvsr_host_model.rd(8'hed, 88, d);
      chk("subq reg", {subqData, 6'h0, {2{subqCrcOk}}}, d);
    end
    u_rcvsr_host_model.rd(8'hee, 8, d);
    chk("unmapped", 88'h0, d);
    $display("subq test done");
  endtask
  // pulse mode with only the subq source enabled: a masked update stays quiet
  task automatic t_pulse;
    @(posedge clk) intPulseMode <= 1'b1;
    intEnable <= 7'h40;
    repeat (2) @(posedge clk);
    evt(1'b1, 1'b0);
    @(negedge clk);
    chk("masked event", 88'h0, 88'(intPin));
    evt(1'b0, 1'b1);
    @(negedge clk);
    chk("pulse high", 88'h1, 88'(intPin));
    @(negedge clk);
    chk("pulse low", 88'h0, 88'(intPin));
    $display("pulse test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {live, rateCode, quadRateSelect, chanStatusBits, chanStatusUpdate} = '0;
    {subqData, subqCrcOk, subqLoad, intPulseMode} = '0;
    intPinIsIrq = 1'b1;
    intEnable = 7'h7f;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_irq;
    t_rate;
    t_subq;
    t_pulse;
    test_done;
  end
  // watchdog: six reads of up to about 720 cycles each, with wide margin
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule

// ==== src/rcvsr_pkg.sv ====
// package of constants and carriers for the receiver status readout
// Notes on behaviour
// - irq source byte: bit0 zero, bits1..7 live and update flags; subq flag clears on read
// - error bit live: 0 when locked and clean, 1 on error or unlock
// - non-pcm bit shows live detector state
// - emphasis bit live: 1 means 50/15 us pre-emphasis
// - validity bit live: 1 means validity error seen
// - rate-updated flag sets on rate result change, clears after irq read
// - chan-status-updated flag sets on 48-bit update, clears after irq read
// - 56-bit rate register: error b1, non-pcm b2, rate b4..6, status bits above
// - error and non-pcm in rate register equal irq register copies
// - 88-bit subq register: crc b0..1, zeros, control, address, track, ... abs frame
// - both crc bits carry the same check result
// - rate code 0 out of range, 1..6 rates, doubled in quad mode, 7 unused
// - level interrupt pin high until irq source read, then low
// - crc flag high when 80 subq bits correct, low on error
package rcvsr_pkg;
  localparam logic [7:0] RCVSR_ADDR_IRQ = 8'heb;
  localparam logic [7:0] RCVSR_ADDR_RATE = 8'hec;
  localparam logic [7:0] RCVSR_ADDR_SUBQ = 8'hed;
  localparam int RCVSR_IRQ_W = 8;
  localparam int RCVSR_RATE_W = 56;
  localparam int RCVSR_SUBQ_W = 88;
  localparam int RCVSR_SHIFT_W = 88;
  localparam int RCVSR_CS_W = 48;
  localparam int RCVSR_Q_W = 80;
  localparam int RCVSR_CNT_W = 7;
  localparam logic [2:0] RCVSR_RATE_NONE = 3'h0;
  localparam logic [2:0] RCVSR_RATE_UNUSED = 3'h7;
  localparam logic [7:0] RCVSR_IRQ_RST = 8'h00;
  // live states from the receiver core
  typedef struct packed {
    logic linkError;
    logic nonPcm;
    logic emphasis;
    logic validityError;
  } rcvsr_live_t;
  // serial interface pins after synchronisation
  typedef struct packed {
    logic chipEnable;
    logic serClk;
    logic [7:0] addr;
  } rcvsr_ser_t;
endpackage

// ==== src/rcvsr_readout.sv ====
// read-only status registers with serial read-out for the audio receiver
`timescale 1ns/1ps
module rcvsr_readout (
  input wire logic clk,
  input wire logic sys_rst,
  // receiver core, same clock domain
  input wire rcvsr_pkg::rcvsr_live_t live,
  input wire logic [2:0] rateCode,
  input wire logic quadRateSelect,
  input wire logic [47:0] chanStatusBits,
  input wire logic chanStatusUpdate,
  input wire logic [79:0] subqData,
  input wire logic subqCrcOk,
  input wire logic subqLoad,
  // interrupt pin configuration from the write side
  input wire logic intPinIsIrq,
  input wire logic intPulseMode,
  input wire logic [6:0] intEnable,
  // three-wire serial interface pins, asynchronous
  input wire logic serChipEnable,
  input wire logic serClk,
  input wire logic [7:0] serAddr,
  output logic serReadData,
  output logic intPin,
  output logic [2:0] rateCodeOut,
  output logic quadRateActive
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  rcvsr_pkg::rcvsr_ser_t serRaw;
  rcvsr_pkg::rcvsr_ser_t serSync;
  assign serRaw = '{chipEnable: serChipEnable, serClk: serClk, addr: serAddr};

  rcvsr_sync #(.W(10)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(serRaw),
    .dout(serSync)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RCVSR_IDLE, RCVSR_SHIFT} rcvsr_state_t;
  rcvsr_state_t state_ff, nxt_state;
  logic ceDly_ff, nxt_ceDly;
  logic clkDly_ff, nxt_clkDly;
  logic [87:0] shift_ff, nxt_shift;
  logic [6:0] bitCnt_ff, nxt_bitCnt;
  logic rateUpd_ff, nxt_rateUpd;
  logic csUpd_ff, nxt_csUpd;
  logic subqUpd_ff, nxt_subqUpd;
  logic [2:0] ratePrev_ff, nxt_ratePrev;
  logic [47:0] csReg_ff, nxt_csReg;
  logic [79:0] subqReg_ff, nxt_subqReg;
  logic crcReg_ff, nxt_crcReg;
  logic [6:0] livePrev_ff, nxt_livePrev;
  logic intPin_ff, nxt_intPin;
  logic serOut_ff, nxt_serOut;
  logic [2:0] rateOut_ff, nxt_rateOut;
  logic quad_ff, nxt_quad;

  logic [7:0] irqByte;
  logic [55:0] rateWord;
  logic [87:0] subqWord;
  logic readStart;
  logic readIrq;
  logic clkRise;
  logic [6:0] srcNow;
  logic irqEvent;

  // ------------------------------------------------------------
  // register images
  // ------------------------------------------------------------
  // live bits straight from the core, sticky ones from flops
  assign irqByte = {subqUpd_ff, csUpd_ff, rateUpd_ff, live.validityError,
                    live.emphasis, live.nonPcm, live.linkError, 1'b0};
  // same sources as the irq byte so the copies can never disagree
  assign rateWord = {csReg_ff, 1'b0, rateCode, 1'b0,
                     live.nonPcm, live.linkError, 1'b0};
  // crc duplicated into bits 0 and 1, high means data correct
  assign subqWord = {subqReg_ff, 6'h00, crcReg_ff, crcReg_ff};

  assign readStart = serSync.chipEnable && !ceDly_ff;
  assign clkRise = serSync.serClk && !clkDly_ff;
  assign readIrq = readStart && (serSync.addr == rcvsr_pkg::RCVSR_ADDR_IRQ);
  assign srcNow = {subqLoad, chanStatusUpdate, rateCode != ratePrev_ff,
                   live.validityError, live.emphasis, live.nonPcm, live.linkError};
  // level sources fire on change, update sources on their pulse
  assign irqEvent = |(intEnable & {srcNow[6:4], srcNow[3:0] ^ livePrev_ff[3:0]});

  // ------------------------------------------------------------
  // capture and sticky flags
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_ratePrev = rateCode;
    nxt_livePrev = srcNow;
    nxt_csReg = chanStatusUpdate ? chanStatusBits : csReg_ff;
    nxt_subqReg = subqLoad ? subqData : subqReg_ff;
    nxt_crcReg = subqLoad ? subqCrcOk : crcReg_ff;
    // a new event in the read cycle wins over the clear
    nxt_rateUpd = (rateCode != ratePrev_ff) || (rateUpd_ff && !readIrq);
    nxt_csUpd = chanStatusUpdate || (csUpd_ff && !readIrq);
    nxt_subqUpd = subqLoad || (subqUpd_ff && !readIrq);
    nxt_rateOut = rateCode;
    nxt_quad = quadRateSelect;
    // pin: emphasis by default, irq when selected
    if (!intPinIsIrq)
      nxt_intPin = live.emphasis;
    else if (intPulseMode)
      nxt_intPin = irqEvent;
    else
      nxt_intPin = irqEvent || (intPin_ff && !readIrq);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ratePrev_ff <= rcvsr_pkg::RCVSR_RATE_NONE;
      livePrev_ff <= 7'h00;
      csReg_ff <= 48'h000000000000;
      subqReg_ff <= 80'h00000000000000000000;
      crcReg_ff <= 1'b0;
      rateUpd_ff <= 1'b0;
      csUpd_ff <= 1'b0;
      subqUpd_ff <= 1'b0;
      intPin_ff <= 1'b0;
      rateOut_ff <= rcvsr_pkg::RCVSR_RATE_NONE;
      quad_ff <= 1'b0;
    end
    else
    begin
      ratePrev_ff <= nxt_ratePrev;
      livePrev_ff <= nxt_livePrev;
      csReg_ff <= nxt_csReg;
      subqReg_ff <= nxt_subqReg;
      crcReg_ff <= nxt_crcReg;
      rateUpd_ff <= nxt_rateUpd;
      csUpd_ff <= nxt_csUpd;
      subqUpd_ff <= nxt_subqUpd;
      intPin_ff <= nxt_intPin;
      rateOut_ff <= nxt_rateOut;
      quad_ff <= nxt_quad;
    end
  end

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  // snapshot at chip-enable rise; bits leave lsb first on each clock rise
  always_comb
  begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_serOut = serOut_ff;
    nxt_ceDly = serSync.chipEnable;
    nxt_clkDly = serSync.serClk;
    case (state_ff)
      RCVSR_IDLE:
      begin
        nxt_serOut = 1'b0;
        if (readStart)
        begin
          nxt_state = RCVSR_SHIFT;
          nxt_bitCnt = 7'h00;
          case (serSync.addr)
            rcvsr_pkg::RCVSR_ADDR_IRQ: nxt_shift = {80'h0, irqByte};
            rcvsr_pkg::RCVSR_ADDR_RATE: nxt_shift = {32'h0, rateWord};
            rcvsr_pkg::RCVSR_ADDR_SUBQ: nxt_shift = subqWord;
            default: nxt_shift = 88'h0;
          endcase
          nxt_serOut = nxt_shift[0];
        end
      end
      RCVSR_SHIFT:
      begin
        if (!serSync.chipEnable)
          nxt_state = RCVSR_IDLE;
        else if (clkRise)
        begin
          nxt_shift = {1'b0, shift_ff[87:1]};
          nxt_serOut = shift_ff[1];
          // stops at the longest register so a host that over-clocks cannot wrap it
          if (bitCnt_ff != 7'(rcvsr_pkg::RCVSR_SHIFT_W))
            nxt_bitCnt = bitCnt_ff + 7'h01;
        end
      end
      default: nxt_state = RCVSR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= RCVSR_IDLE;
      shift_ff <= 88'h0;
      bitCnt_ff <= 7'h00;
      serOut_ff <= 1'b0;
      ceDly_ff <= 1'b0;
      clkDly_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      serOut_ff <= nxt_serOut;
      ceDly_ff <= nxt_ceDly;
      clkDly_ff <= nxt_clkDly;
    end
  end

  assign serReadData = serOut_ff;
  assign intPin = intPin_ff;
  assign rateCodeOut = rateOut_ff;
  assign quadRateActive = quad_ff;
endmodule

// ==== src/rcvsr_sync.sv ====
// two flip-flop synchroniser, parameterised width
`timescale 1ns/1ps
module rcvsr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] nxt_stage1;
  logic [W-1:0] nxt_stage2;

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_stage1 = din;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign dout = stage2_ff;
endmodule
